// ---- verilog/rtcaf_pkg.sv ----
// constants shared by both ends of the rtc alarm and flag block
// ****************************************************************
// Overview of operation
// - power-up clears halt, square, enables, steer
// - four mask bits pick alarm rate
// - undefined mask patterns act once per second
// - day-or-date bit picks date or weekday
// - unmasked match sets alarm match flag
// - alarm flag with enable raises interrupt
// - halt bit zero runs oscillator
// - square output follows oscillator unless disabled
// - backup square enable keeps wave on battery with aux supply
// - two read-only battery-low bits 7 and 6
// - power-fail floats request unless hold set
// - release bit zero drives request low
// - alarm-power or wake key clears release bit
// - read or zero-write clears alarm, key flags
// - wake key event or write sets key flag
// - watchdog timeout sets flag, zero-write clears
// - pending is OR of three enabled flags
// - flag read clears flags after strobe ends
// - interrupt releases only after pending clears
// - alarm power enable drives request independently
// - alarm wakeup needs transfers enabled
// ****************************************************************
package rtcaf_pkg;
  localparam logic [4:0] ADDR_SEC      = 5'h00;
  localparam logic [4:0] ADDR_MIN      = 5'h01;
  localparam logic [4:0] ADDR_HOUR     = 5'h02;
  localparam logic [4:0] ADDR_DAY      = 5'h03;
  localparam logic [4:0] ADDR_DATE     = 5'h04;
  localparam logic [4:0] ADDR_MONTH    = 5'h05;
  localparam logic [4:0] ADDR_ALM_SEC  = 5'h08;
  localparam logic [4:0] ADDR_ALM_MIN  = 5'h09;
  localparam logic [4:0] ADDR_ALM_HOUR = 5'h0a;
  localparam logic [4:0] ADDR_ALM_DAY  = 5'h0b;
  localparam logic [4:0] ADDR_WD_LO    = 5'h0c;
  localparam logic [4:0] ADDR_WD_HI    = 5'h0d;
  localparam logic [4:0] ADDR_FLAGS    = 5'h0e;
  localparam logic [4:0] ADDR_CTRL     = 5'h0f;
  // month register bits
  localparam int BIT_OSC_HALT   = 7;
  localparam int BIT_SQ_DIS     = 6;
  localparam int BIT_BK_SQ      = 5;
  // flag register bits
  localparam int BIT_MAIN_LOW   = 7;
  localparam int BIT_AUX_LOW    = 6;
  localparam int BIT_PWR_HOLD   = 5;
  localparam int BIT_PWR_REL    = 4;
  localparam int BIT_ALM_FLAG   = 3;
  localparam int BIT_KEY_FLAG   = 2;
  localparam int BIT_TMO_FLAG   = 1;
  localparam int BIT_IRQ_PEND   = 0;
  // control register bits, then alarm register mask and day-select bits
  localparam int BIT_XFER_EN    = 7;
  localparam int BIT_ALM_PWR_EN = 4;
  localparam int BIT_ALM_IRQ_EN = 3;
  localparam int BIT_KEY_IRQ_EN = 2;
  localparam int BIT_WD_EN      = 1;
  localparam int BIT_WD_STEER   = 0;
  localparam int BIT_ALM_MASK   = 7;
  localparam int BIT_DAY_SEL    = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // host strobe timing: address hold of 15 ns before the clearing edge
  localparam int CLOCK_NS       = 40;
  localparam int ADDR_HOLD_NS   = 15;
  localparam int ADDR_HOLD_CYC  =
    (ADDR_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
endpackage : rtcaf_pkg

// ---- verilog/rtcaf_bus_if.sv ----
// byte bus and pins between the host and the rtc flag block
`timescale 1ns/10ps
`default_nettype none
interface rtcaf_bus_if;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       cs_n;
  logic       oe_n;
  logic       we_n;
  logic       irq_n;
  logic       power_on_request_n;
  logic       power_on_request_oe;
  modport dev (
    input  addr, wdata, cs_n, oe_n, we_n,
    output rdata, irq_n, power_on_request_n, power_on_request_oe
  );
  modport host (
    output addr, wdata, cs_n, oe_n, we_n,
    input  rdata, irq_n, power_on_request_n, power_on_request_oe
  );
endinterface : rtcaf_bus_if
`default_nettype wire

// ---- verilog/rtcaf_device.sv ----
// device end: alarm compare, control bits, flags and outputs
`timescale 1ns/10ps
`default_nettype none
module rtcaf_device (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  rtcaf_bus_if.dev        bus,
  input  wire logic       osc_tick_i,
  input  wire logic       second_tick_i,
  input  wire logic       kick_input_n_i,
  input  wire logic       watchdog_timeout_i,
  input  wire logic       power_fail_i,
  input  wire logic       on_battery_i,
  input  wire logic       aux_supply_i,
  input  wire logic       main_battery_low_i,
  input  wire logic       aux_battery_low_i,
  output logic            oscillator_run_o,
  output logic            square_wave_out_o,
  output logic            watchdog_kick_o
);
  import rtcaf_pkg::*;

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] regs_q [0:15];
  logic [7:0] regs_d [0:15];
  logic [3:0] flags_q, flags_d;   // alarm, key, timeout, pending
  logic       rel_q, rel_d, hold_q, hold_d;
  logic       kick_q, sq_q, sq_d;
  logic       rd_act_q, rd_act_d;
  logic [1:0] hold_cnt_q, hold_cnt_d;
  logic [4:0] rd_addr_q, rd_addr_d;
  logic       fail_q;

  wire        rd_on  = !bus.cs_n && !bus.oe_n;
  wire        wr_on  = !bus.cs_n && !bus.we_n && bus.oe_n;
  wire        sel_lo = (bus.addr[4] == 1'b0);
  wire [3:0]  idx    = bus.addr[3:0];

  // ****************************************************************
  // alarm compare
  // ****************************************************************
  logic [3:0] mask;
  logic       alm_hit, day_sel;
  logic [5:0] day_ref;
  always_comb begin
    mask    = {regs_q[ADDR_ALM_DAY[3:0]][BIT_ALM_MASK],
               regs_q[ADDR_ALM_HOUR[3:0]][BIT_ALM_MASK],
               regs_q[ADDR_ALM_MIN[3:0]][BIT_ALM_MASK],
               regs_q[ADDR_ALM_SEC[3:0]][BIT_ALM_MASK]};
    day_sel = regs_q[ADDR_ALM_DAY[3:0]][BIT_DAY_SEL];
    day_ref = day_sel ? regs_q[ADDR_DAY[3:0]][5:0]
                      : regs_q[ADDR_DATE[3:0]][5:0];
    unique case (mask)
      4'b1110: alm_hit = regs_q[0][6:0] == regs_q[8][6:0];
      4'b1100: alm_hit = regs_q[0][6:0] == regs_q[8][6:0]
                      && regs_q[1][6:0] == regs_q[9][6:0];
      4'b1000: alm_hit = regs_q[0][6:0] == regs_q[8][6:0]
                      && regs_q[1][6:0] == regs_q[9][6:0]
                      && regs_q[2][5:0] == regs_q[10][5:0];
      4'b0000: alm_hit = regs_q[0][6:0] == regs_q[8][6:0]
                      && regs_q[1][6:0] == regs_q[9][6:0]
                      && regs_q[2][5:0] == regs_q[10][5:0]
                      && day_ref == regs_q[11][5:0];
      default: alm_hit = 1'b1;
    endcase
  end

  wire xfer_en  = regs_q[ADDR_CTRL[3:0]][BIT_XFER_EN];
  // compare only on the update tick so each second matches once
  wire alm_evt  = second_tick_i && xfer_en && alm_hit;
  wire key_evt  = kick_q && !kick_input_n_i;
  wire [7:0] ctl = regs_q[ADDR_CTRL[3:0]];

  // ****************************************************************
  // bus and flag next state
  // ****************************************************************
  logic [7:0] flag_byte;
  logic       clr_rd;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      regs_d[i] = regs_q[i];
    end
    flags_d    = flags_q;
    rel_d      = rel_q;
    hold_d     = hold_q;
    rd_act_d   = rd_act_q;
    hold_cnt_d = hold_cnt_q;
    rd_addr_d  = rd_addr_q;
    clr_rd     = 1'b0;
    // flag read: arm once address held, clear when strobe ends
    if (rd_on && bus.addr == ADDR_FLAGS) begin
      if (bus.addr != rd_addr_q) begin
        hold_cnt_d = 2'h0;
      end else if (hold_cnt_q != 2'(ADDR_HOLD_CYC)) begin
        hold_cnt_d = hold_cnt_q + 2'h1;
      end else begin
        rd_act_d = 1'b1;
      end
    end
    if (rd_act_q && (!rd_on || bus.addr != ADDR_FLAGS)) begin
      clr_rd   = 1'b1;
      rd_act_d = 1'b0;
      hold_cnt_d = 2'h0;
    end
    rd_addr_d = rd_on ? bus.addr : 5'h1f;
    if (clr_rd) begin
      flags_d = 4'h0;
    end
    if (wr_on && sel_lo) begin
      if (idx == ADDR_FLAGS[3:0]) begin
        hold_d = bus.wdata[BIT_PWR_HOLD];
        rel_d  = bus.wdata[BIT_PWR_REL];
        if (!bus.wdata[BIT_ALM_FLAG]) flags_d[3] = 1'b0;
        if (!bus.wdata[BIT_KEY_FLAG]) flags_d[2] = 1'b0;
        else flags_d[2] = 1'b1;
        if (!bus.wdata[BIT_TMO_FLAG]) flags_d[1] = 1'b0;
      end else begin
        regs_d[idx] = bus.wdata;
      end
    end
    // hardware events win over any clear in the same cycle
    if (alm_evt) flags_d[3] = 1'b1;
    if (key_evt) flags_d[2] = 1'b1;
    if (watchdog_timeout_i) flags_d[1] = 1'b1;
    // pending follows the enabled flags, so the pin drops with it
    flags_d[0] = (flags_d[3] && ctl[BIT_ALM_IRQ_EN])
              || (flags_d[2] && ctl[BIT_KEY_IRQ_EN])
              || (flags_d[1] && ctl[BIT_WD_EN]);
    if ((flags_d[3] && ctl[BIT_ALM_PWR_EN]) || flags_d[2]) begin
      rel_d = 1'b0;
    end
    flag_byte = {main_battery_low_i, aux_battery_low_i,
                 hold_q, rel_q, flags_q};
  end

  // ****************************************************************
  // square wave
  // ****************************************************************
  always_comb begin
    sq_d = 1'b0;
    if (!regs_q[ADDR_MONTH[3:0]][BIT_OSC_HALT]) begin
      if (on_battery_i) begin
        sq_d = regs_q[ADDR_MONTH[3:0]][BIT_BK_SQ]
            && aux_supply_i && osc_tick_i;
      end else begin
        sq_d = !regs_q[ADDR_MONTH[3:0]][BIT_SQ_DIS]
            && osc_tick_i;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= RESET_BYTE;
      end
      flags_q    <= 4'h0;
      rel_q      <= 1'b1;
      hold_q     <= 1'b0;
      kick_q     <= 1'b1;
      sq_q       <= 1'b0;
      rd_act_q   <= 1'b0;
      hold_cnt_q <= 2'h0;
      rd_addr_q  <= 5'h1f;
      fail_q     <= 1'b0;
    end else begin
      regs_q     <= regs_d;
      flags_q    <= flags_d;
      rel_q      <= rel_d;
      hold_q     <= hold_d;
      kick_q     <= kick_input_n_i;
      sq_q       <= sq_d;
      rd_act_q   <= rd_act_d;
      hold_cnt_q <= hold_cnt_d;
      rd_addr_q  <= rd_addr_d;
      fail_q     <= power_fail_i;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic [7:0] rdata_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (!sel_lo) begin
      rdata_q <= 8'h00;
    end else if (idx == ADDR_FLAGS[3:0]) begin
      rdata_q <= flag_byte;
    end else begin
      rdata_q <= regs_q[idx];
    end
  end
  assign bus.rdata = rdata_q;
  assign bus.irq_n = !flags_q[0];
  // open-drain request: driven low only, floats when released
  assign bus.power_on_request_n  = 1'b0;
  assign bus.power_on_request_oe = !rel_q
                                && (!fail_q || hold_q);
  assign oscillator_run_o  = !regs_q[ADDR_MONTH[3:0]][BIT_OSC_HALT];
  assign square_wave_out_o = sq_q;
  assign watchdog_kick_o   = wr_on && sel_lo
                          && (idx == ADDR_WD_LO[3:0] || idx == ADDR_WD_HI[3:0]);
endmodule : rtcaf_device
`default_nettype wire

// ---- verilog/rtcaf_host.sv ----
// host end: drives byte reads and writes of the flag block
`timescale 1ns/10ps
`default_nettype none
module rtcaf_host (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  rtcaf_bus_if.host       bus,
  input  wire logic       req_i,
  input  wire logic       req_write_i,
  input  wire logic [4:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic            irq_o
);
  import rtcaf_pkg::*;

  typedef enum logic [1:0] {
    RTCAF_IDLE = 2'b00,
    RTCAF_HOLD = 2'b01,
    RTCAF_END  = 2'b10
  } rtcaf_state_e;

  rtcaf_state_e st_q, st_d;
  logic [4:0] addr_q, addr_d;
  logic [7:0] wd_q, wd_d, rd_q, rd_d;
  logic       wr_q, wr_d, done_q, done_d;
  logic [1:0] cnt_q, cnt_d;

  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    unique case (st_q)
      RTCAF_IDLE: begin
        if (req_i) begin
          addr_d = req_addr_i;
          wd_d   = req_wdata_i;
          wr_d   = req_write_i;
          cnt_d  = 2'h0;
          st_d   = RTCAF_HOLD;
        end
      end
      RTCAF_HOLD: begin
        // hold address beyond the device's settle count
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == 2'(ADDR_HOLD_CYC + 1)) begin
          st_d = RTCAF_END;
        end
      end
      RTCAF_END: begin
        rd_d   = bus.rdata;
        done_d = 1'b1;
        st_d   = RTCAF_IDLE;
      end
      default: st_d = RTCAF_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= RTCAF_IDLE;
      addr_q <= 5'h00;
      wd_q   <= 8'h00;
      rd_q   <= 8'h00;
      wr_q   <= 1'b0;
      cnt_q  <= 2'h0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  wire act = (st_q == RTCAF_HOLD);
  assign bus.addr  = addr_q;
  assign bus.wdata = wd_q;
  assign bus.cs_n  = !act;
  assign bus.oe_n  = !(act && !wr_q);
  assign bus.we_n  = !(act && wr_q);
  assign busy_o    = (st_q != RTCAF_IDLE);
  assign done_o    = done_q;
  assign rdata_o   = rd_q;
  assign irq_o     = !bus.irq_n;
endmodule : rtcaf_host
`default_nettype wire

// ---- testbench/rtcaf_sva.sv ----
// bus checker for the rtc flag block, fed from the interface signals
`timescale 1ns/10ps
`default_nettype none
module rtcaf_sva
  import rtcaf_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       cs_n,
  input wire logic       oe_n,
  input wire logic       we_n,
  input wire logic       irq_n,
  input wire logic       power_on_request_n,
  input wire logic       power_on_request_oe
);
  // ****************************************************************
  // bus and pin properties
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_pin_low:
    assert property (power_on_request_n == 1'b0)
    else $error("request pin not low");
  // release bit comes out of reset set, so the pin floats
  a_float_reset:
    assert property ($past(rst_i) |-> !power_on_request_oe)
    else $error("request pin driven after reset");
  a_strobe_hold:
    assert property ($fell(cs_n) |-> !cs_n [*3] ##1 cs_n)
    else $error("select length wrong");
  a_addr_stable:
    assert property (!cs_n && !$past(cs_n) |-> $stable(addr))
    else $error("address moved in strobe");
  a_strobe_pair:
    assert property (!cs_n |-> oe_n != we_n)
    else $error("strobes clash");
  a_strobe_idle:
    assert property (cs_n |-> oe_n && we_n)
    else $error("strobe without select");
  a_flag_clear:
    assert property ($rose(cs_n) && !$past(oe_n) && $past(addr) == ADDR_FLAGS
      |=> irq_n)
    else $error("flag read left interrupt");
  // with the bus idle nothing may clear the pending flag
  a_irq_hold:
    assert property (!irq_n && cs_n && $past(cs_n) |=> !irq_n)
    else $error("interrupt released early");
  // a release needs a bus access within the last two cycles
  a_irq_release:
    assert property ($rose(irq_n) |-> !$past(cs_n) || !$past(cs_n, 2))
    else $error("interrupt released without access");
endmodule : rtcaf_sva
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench: host and device ends joined over the byte bus
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rtcaf_pkg::*;
  typedef struct {
    logic       wr;
    logic [4:0] a;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] e;
  } rtcaf_row_s;
  logic       clock_i, rst_i, req_i, req_write_i, busy_o, done_o, irq_o;
  logic [4:0] req_addr_i;
  logic [7:0] req_wdata_i, rdata_o, rd;
  logic       osc_tick, sec_tick, kick_n, wd_tmo, pfail, on_bat;
  logic       main_low, aux_low, osc_run, sq_out, wd_kick, aux;
  int         num_errors, num_checks, cycles, kicks;
  rtcaf_row_s rows [8];
  rtcaf_bus_if bus_i ();
  rtcaf_device rtcaf_device_i (
    .clock_i(clock_i), .rst_i(rst_i), .bus(bus_i), .osc_tick_i(osc_tick),
    .second_tick_i(sec_tick), .kick_input_n_i(kick_n),
    .watchdog_timeout_i(wd_tmo), .power_fail_i(pfail), .on_battery_i(on_bat),
    .aux_supply_i(aux), .main_battery_low_i(main_low),
    .aux_battery_low_i(aux_low), .oscillator_run_o(osc_run),
    .square_wave_out_o(sq_out), .watchdog_kick_o(wd_kick));
  rtcaf_host rtcaf_host_i (
    .clock_i(clock_i), .rst_i(rst_i), .bus(bus_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .irq_o(irq_o));
  rtcaf_sva rtcaf_sva_i (
    .clock_i(clock_i), .rst_i(rst_i), .addr(bus_i.addr),
    .wdata(bus_i.wdata), .rdata(bus_i.rdata), .cs_n(bus_i.cs_n),
    .oe_n(bus_i.oe_n), .we_n(bus_i.we_n), .irq_n(bus_i.irq_n),
    .power_on_request_n(bus_i.power_on_request_n),
    .power_on_request_oe(bus_i.power_on_request_oe));
  // ****************************************************************
  // clock, watchdog on the run and shared tasks
  // ****************************************************************
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      complete_run();
    end
  end
  always @(posedge clock_i) begin
    if (wd_kick) begin
      kicks++;
    end
  end
  task automatic complete_run();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic pins(input logic [1:0] e);
    check({6'h00, irq_o, bus_i.power_on_request_oe}, {6'h00, e});
  endtask : pins
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    tick(1);
    req_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    tick(1);
    req_i = 1'b0;
    while (done_o !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check({6'h00, done_o, busy_o}, 8'h02);
    rd = rdata_o;
  endtask : xfer
  task automatic rdchk(input logic [4:0] a, input logic [7:0] m,
                       input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(rd & m, e);
  endtask : rdchk
  task automatic sq(input logic [7:0] m, input logic bat, input logic [1:0] e);
    xfer(1'b1, ADDR_MONTH, m);
    on_bat = bat;
    osc_tick = 1'b1;
    tick(3);
    check({6'h00, osc_run, sq_out}, {6'h00, e});
    osc_tick = 1'b0;
    tick(3);
    check({7'h00, sq_out}, 8'h00);
  endtask : sq
  // alarm bytes packed seconds first; e is {interrupt, request pin}
  task automatic alm(input logic [31:0] r, input logic [1:0] e);
    xfer(1'b1, ADDR_FLAGS, 8'h10);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ADDR_ALM_SEC + 5'(i), r[31-8*i -: 8]);
    end
    sec_tick = 1'b1;
    tick(1);
    sec_tick = 1'b0;
    tick(3);
    pins(e);
    rdchk(ADDR_FLAGS, 8'h19, {3'h0, ~e[0], |e, 2'h0, e[1]});
    tick(1);
    check({7'h00, irq_o}, 8'h00);
  endtask : alm
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {clock_i, req_i, req_write_i, req_addr_i, req_wdata_i} = '0;
    {osc_tick, sec_tick, wd_tmo, pfail, on_bat, main_low, aux_low} = '0;
    {rst_i, kick_n, aux} = 3'b111;
    {num_errors, num_checks, cycles, kicks} = '0;
    rows = '{'{1'b0, ADDR_MONTH, 8'h00, 8'he0, 8'h00},
             '{1'b0, ADDR_CTRL, 8'h00, 8'h0f, 8'h00},
             '{1'b1, ADDR_MONTH, 8'he0, 8'he0, 8'he0},
             '{1'b1, ADDR_ALM_DAY, 8'h45, 8'hff, 8'h45},
             '{1'b1, ADDR_FLAGS, 8'h00, 8'h10, 8'h00},
             '{1'b1, ADDR_FLAGS, 8'h10, 8'h10, 8'h10},
             '{1'b1, 5'h13, 8'h5a, 8'hff, 8'h00},
             '{1'b1, ADDR_FLAGS, 8'hc0, 8'hc0, 8'h00}};
    tick(5);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        xfer(1'b1, rows[i].a, rows[i].d);
      end
      rdchk(rows[i].a, rows[i].m, rows[i].e);
    end
    sq(8'h00, 1'b0, 2'b11);
    sq(8'h80, 1'b0, 2'b00);
    sq(8'h40, 1'b0, 2'b10);
    sq(8'h20, 1'b1, 2'b11);
    sq(8'h00, 1'b1, 2'b10);
    aux = 1'b0;
    sq(8'h20, 1'b1, 2'b10);
    aux = 1'b1;
    on_bat = 1'b0;
    main_low = 1'b1;
    rdchk(ADDR_FLAGS, 8'hc0, 8'h80);
    {main_low, aux_low} = 2'b01;
    rdchk(ADDR_FLAGS, 8'hc0, 8'h40);
    aux_low = 1'b0;
    xfer(1'b1, ADDR_SEC, 8'h30);
    xfer(1'b1, ADDR_MIN, 8'h15);
    xfer(1'b1, ADDR_HOUR, 8'h08);
    xfer(1'b1, ADDR_DAY, 8'h05);
    xfer(1'b1, ADDR_DATE, 8'h09);
    xfer(1'b1, ADDR_CTRL, 8'h98);
    alm(32'h30808080, 2'b11);
    alm(32'h31808080, 2'b00);
    alm(32'h30158080, 2'b11);
    alm(32'h30168080, 2'b00);
    alm(32'h30150880, 2'b11);
    alm(32'h30150845, 2'b11);
    alm(32'h30150805, 2'b00);
    alm(32'h30150809, 2'b11);
    alm(32'hb1168805, 2'b11);
    alm(32'hffffffff, 2'b11);
    xfer(1'b1, ADDR_CTRL, 8'h18);
    alm(32'hffffffff, 2'b00);
    xfer(1'b1, ADDR_CTRL, 8'h90);
    alm(32'hffffffff, 2'b01);
    xfer(1'b1, ADDR_FLAGS, 8'h20);
    pfail = 1'b1;
    tick(2);
    pins(2'b01);
    pfail = 1'b0;
    xfer(1'b1, ADDR_FLAGS, 8'h00);
    pfail = 1'b1;
    tick(2);
    pins(2'b00);
    pfail = 1'b0;
    xfer(1'b1, ADDR_CTRL, 8'h84);
    xfer(1'b1, ADDR_FLAGS, 8'h10);
    kick_n = 1'b0;
    tick(3);
    pins(2'b11);
    kick_n = 1'b1;
    rdchk(ADDR_FLAGS, 8'h15, 8'h05);
    tick(1);
    pins(2'b01);
    xfer(1'b1, ADDR_FLAGS, 8'h04);
    tick(2);
    pins(2'b11);
    xfer(1'b1, ADDR_FLAGS, 8'h00);
    tick(2);
    pins(2'b01);
    xfer(1'b1, ADDR_CTRL, 8'h80);
    wd_tmo = 1'b1;
    tick(1);
    wd_tmo = 1'b0;
    tick(3);
    pins(2'b01);
    rdchk(ADDR_FLAGS, 8'h03, 8'h02);
    xfer(1'b1, ADDR_CTRL, 8'h82);
    wd_tmo = 1'b1;
    tick(1);
    wd_tmo = 1'b0;
    tick(3);
    pins(2'b11);
    xfer(1'b1, ADDR_FLAGS, 8'h00);
    tick(2);
    pins(2'b01);
    check(8'(kicks), 8'h00);
    xfer(1'b1, ADDR_WD_LO, 8'h01);
    check({7'h00, kicks != 0}, 8'h01);
    xfer(1'b1, ADDR_MONTH, 8'hc0);
    xfer(1'b1, ADDR_CTRL, 8'h0f);
    rst_i = 1'b1;
    tick(3);
    rst_i = 1'b0;
    pins(2'b00);
    check({7'h00, osc_run}, 8'h01);
    rdchk(ADDR_MONTH, 8'hc0, 8'h00);
    rdchk(ADDR_CTRL, 8'h0f, 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire
